// ===== sadc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Convert only the one selected input
// - Run bit write starts conversion
// - Completion loads both results, raises request
// - Restart immediately while run stays set
// - Mode or channel write restarts conversion
// - Run bit cleared stops at once
// - Channel change gives exact conversion time
// - Result read beats simultaneous update
// - Config write beats completion, no update
// - Stop state halts the converter
// - Sample lasts one sixth of conversion
// - Successive approximation, msb first, ten bits
// - High byte holds upper eight bits
// - Channel write keeps pending done flag
module sadc_ctrl #(
    parameter int UNIT_BASE = sadc_pkg::UNIT_BASE
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // Register port
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Analog front end
    input  wire logic       comp_in,
    input  wire logic       stop_mode,
    output logic      [1:0] channel_sel,
    output logic            sample_en,
    output logic      [9:0] dac_code,
    output logic            comparator_power_enable,
    // Completion request
    output logic            conversion_done_irq
);

    // ------------------------------------------------------------
    // Comparator synchroniser
    // ------------------------------------------------------------
    logic [2:0] comp_sync_q;
    logic       comp_q;
    logic       comp_d;

    always_comb begin
        comp_d = comp_q;
        if (comp_sync_q[1] == comp_sync_q[2]) begin
            comp_d = comp_sync_q[2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            comp_sync_q <= 3'h0;
            comp_q      <= 1'b0;
        end else begin
            comp_sync_q <= {comp_sync_q[1:0], comp_in};
            comp_q      <= comp_d;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  mode_q;
    logic [7:0]  mode_d;
    logic [1:0]  chan_q;
    logic [1:0]  chan_d;
    logic        flag_q;
    logic        flag_d;
    logic [15:0] res_word_q;
    logic [15:0] res_word_d;
    logic [7:0]  res_byte_q;
    logic [7:0]  res_byte_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;
    logic        irq_q;
    logic        irq_d;
    logic        wr_mode;
    logic        wr_chan;
    logic        cfg_wr;
    logic        done_now;
    logic [9:0]  sar_final;

    assign wr_mode = reg_wr && (reg_addr == sadc_pkg::OFS_MODE);
    assign wr_chan = reg_wr && (reg_addr == sadc_pkg::OFS_CHAN);
    assign cfg_wr  = wr_mode || wr_chan;

    always_comb begin
        mode_d     = mode_q;
        chan_d     = chan_q;
        flag_d     = flag_q;
        res_word_d = res_word_q;
        res_byte_d = res_byte_q;
        irq_d      = 1'b0;
        rdata_d    = 8'h00;
        if (wr_mode) begin
            mode_d = reg_wdata;
        end
        if (wr_chan) begin
            chan_d = reg_wdata[1:0];
        end
        if (reg_wr && (reg_addr == sadc_pkg::OFS_FLAG)
            && reg_wdata[sadc_pkg::FLAG_DONE_BIT]) begin
            flag_d = 1'b0;
        end
        if (done_now) begin
            res_word_d = {sar_final, 6'h00};
            res_byte_d = sar_final[9:2];
            irq_d      = 1'b1;
            // Set wins over a clear in the same cycle
            flag_d     = 1'b1;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                sadc_pkg::OFS_MODE:     rdata_d = mode_q & 8'hb9;
                sadc_pkg::OFS_CHAN:     rdata_d = {6'h00, chan_q};
                sadc_pkg::OFS_RES_LO:   rdata_d = res_word_q[7:0];
                sadc_pkg::OFS_RES_HI:   rdata_d = res_word_q[15:8];
                sadc_pkg::OFS_RES_BYTE: rdata_d = res_byte_q;
                sadc_pkg::OFS_FLAG:     rdata_d = {7'h00, flag_q};
                default:                rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            mode_q     <= sadc_pkg::MODE_RST;
            chan_q     <= sadc_pkg::CHAN_RST;
            flag_q     <= 1'b0;
            res_word_q <= 16'h0000;
            res_byte_q <= 8'h00;
            rdata_q    <= 8'h00;
            irq_q      <= 1'b0;
        end else begin
            mode_q     <= mode_d;
            chan_q     <= chan_d;
            flag_q     <= flag_d;
            res_word_q <= res_word_d;
            res_byte_q <= res_byte_d;
            rdata_q    <= rdata_d;
            irq_q      <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    sadc_pkg::sadc_state_t st_q;
    sadc_pkg::sadc_state_t st_d;
    logic [1:0] samp_q;
    logic [1:0] samp_d;
    logic [3:0] idx_q;
    logic [3:0] idx_d;
    logic [9:0] sar_q;
    logic [9:0] sar_d;
    logic       run_now;
    logic       tick;

    // The new mode value governs the restart, so a run write acts at once
    assign run_now = wr_mode ? reg_wdata[sadc_pkg::MODE_RUN_BIT]
                             : mode_q[sadc_pkg::MODE_RUN_BIT];

    always_comb begin
        sar_final = sar_q;
        if (!comp_q) begin
            sar_final[idx_q] = 1'b0;
        end
    end

    always_comb begin
        st_d     = st_q;
        samp_d   = samp_q;
        idx_d    = idx_q;
        sar_d    = sar_q;
        done_now = 1'b0;
        unique case (st_q)
            sadc_pkg::ST_IDLE: begin
                sar_d = 10'h000;
            end
            sadc_pkg::ST_SAMPLE: begin
                if (tick) begin
                    samp_d = samp_q + 2'h1;
                    if (samp_q == sadc_pkg::SAMPLE_UNITS - 2'h1) begin
                        st_d  = sadc_pkg::ST_CONVERT;
                        idx_d = sadc_pkg::TOP_BIT;
                        sar_d = 10'h200;
                    end
                end
            end
            sadc_pkg::ST_CONVERT: begin
                if (tick) begin
                    sar_d = sar_final;
                    if (idx_q == 4'h0) begin
                        done_now = !cfg_wr;
                        st_d     = sadc_pkg::ST_SAMPLE;
                        samp_d   = 2'h0;
                    end else begin
                        idx_d        = idx_q - 4'h1;
                        sar_d[idx_d] = 1'b1;
                    end
                end
            end
            default: begin
                st_d = sadc_pkg::ST_IDLE;
            end
        endcase
        if (cfg_wr) begin
            st_d   = run_now ? sadc_pkg::ST_SAMPLE : sadc_pkg::ST_IDLE;
            samp_d = 2'h0;
            idx_d  = sadc_pkg::TOP_BIT;
        end
        if (!run_now) begin
            st_d = sadc_pkg::ST_IDLE;
        end
        if (stop_mode) begin
            st_d = sadc_pkg::ST_IDLE;
        end else if (st_q == sadc_pkg::ST_IDLE && run_now) begin
            st_d   = sadc_pkg::ST_SAMPLE;
            samp_d = 2'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            st_q   <= sadc_pkg::ST_IDLE;
            samp_q <= 2'h0;
            idx_q  <= sadc_pkg::TOP_BIT;
            sar_q  <= 10'h000;
        end else begin
            st_q   <= st_d;
            samp_q <= samp_d;
            idx_q  <= idx_d;
            sar_q  <= sar_d;
        end
    end

    sadc_unit_timer #(
        .BASE (UNIT_BASE)
    ) u_timer (
        .core_clk (core_clk),
        .nrst     (nrst),
        .clear    (cfg_wr || st_q == sadc_pkg::ST_IDLE),
        .enable   (st_q != sadc_pkg::ST_IDLE),
        .fr_sel   (mode_q[sadc_pkg::MODE_FR_LSB +: 3]),
        .tick     (tick)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // one selected input
    assign channel_sel             = chan_q;
    assign sample_en               = (st_q == sadc_pkg::ST_SAMPLE);
    assign dac_code                = sar_q;
    assign comparator_power_enable = mode_q[sadc_pkg::MODE_CE_BIT];
    assign conversion_done_irq     = irq_q;
    assign reg_rdata               = rdata_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [11:0] since_cfg_q;
    logic        first_q;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            since_cfg_q <= 12'h000;
            first_q     <= 1'b0;
        end else if (cfg_wr) begin
            since_cfg_q <= 12'h000;
            first_q     <= 1'b1;
        end else begin
            since_cfg_q <= since_cfg_q + 12'h001;
            // Measurement ends at completion or once idle
            if (irq_q || st_q == sadc_pkg::ST_IDLE) begin
                first_q <= 1'b0;
            end
        end
    end

    a_run_starts: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (wr_mode && reg_wdata[7] && !stop_mode) |=> st_q == sadc_pkg::ST_SAMPLE)
        else $error("run write did not start sampling");

    a_stop_now: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (wr_mode && !reg_wdata[7]) |=> st_q == sadc_pkg::ST_IDLE && !irq_q)
        else $error("run clear did not stop");

    a_chan_restart: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (wr_chan && st_q == sadc_pkg::ST_CONVERT && run_now && !stop_mode)
        |=> st_q == sadc_pkg::ST_SAMPLE && samp_q == 2'h0)
        else $error("channel write did not restart");

    a_done_loads: assert property (
        @(posedge core_clk) disable iff (!nrst)
        irq_q |-> res_word_q == {$past(sar_final), 6'h00} && flag_q)
        else $error("completion did not load result");

    a_write_wins: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (st_q == sadc_pkg::ST_CONVERT && tick && idx_q == 4'h0 && cfg_wr)
        |=> !irq_q && $stable(res_word_q))
        else $error("completion not suppressed by write");

    a_result_stable: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !irq_q |-> $stable(res_word_q) && $stable(res_byte_q))
        else $error("result changed without completion");

    a_high_byte: assert property (
        @(posedge core_clk) disable iff (!nrst)
        res_byte_q == res_word_q[15:8])
        else $error("high byte mismatch");

    a_back_to_back: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (irq_q && mode_q[7] && !$past(stop_mode)) |-> st_q == sadc_pkg::ST_SAMPLE)
        else $error("no immediate restart");

    a_sample_len: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (st_q == sadc_pkg::ST_SAMPLE && tick && samp_q == 2'h1 && !cfg_wr
         && run_now && !stop_mode) |=> st_q == sadc_pkg::ST_CONVERT && sar_q == 10'h200)
        else $error("sample phase length wrong");

    a_flag_kept: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (wr_chan && flag_q) |=> flag_q)
        else $error("channel write cleared flag");

    a_read_first: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (reg_rd && reg_addr == sadc_pkg::OFS_RES_BYTE && done_now)
        |=> reg_rdata == $past(res_byte_q))
        else $error("read saw new result");

    a_conv_time: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (irq_q && first_q) |-> 32'(since_cfg_q) ==
            12 * (32'(mode_q[5:3]) + 1) * UNIT_BASE)
        else $error("conversion time after restart wrong");

    a_stop_halts: assert property (
        @(posedge core_clk) disable iff (!nrst)
        stop_mode |=> st_q == sadc_pkg::ST_IDLE)
        else $error("stop state did not halt");

endmodule // sadc_ctrl

`default_nettype wire

// ===== sadc_pkg.sv
package sadc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [2:0] OFS_MODE      = 3'h0;
    localparam logic [2:0] OFS_CHAN      = 3'h1;
    localparam logic [2:0] OFS_RES_LO    = 3'h2;
    localparam logic [2:0] OFS_RES_HI    = 3'h3;
    localparam logic [2:0] OFS_RES_BYTE  = 3'h4;
    localparam logic [2:0] OFS_FLAG      = 3'h5;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         MODE_RUN_BIT  = 7;
    localparam int         MODE_FR_LSB   = 3;
    localparam int         MODE_CE_BIT   = 0;
    localparam int         FLAG_DONE_BIT = 0;
    localparam logic [7:0] MODE_RST      = 8'h00;
    localparam logic [1:0] CHAN_RST      = 2'h0;
    localparam int         RES_SHIFT     = 6;

    // ------------------------------------------------------------
    // Conversion timing, in timer units
    // ------------------------------------------------------------
    localparam int         SAR_BITS      = 10;
    localparam logic [1:0] SAMPLE_UNITS  = 2'h2;
    localparam logic [3:0] TOP_BIT       = 4'h9;
    localparam int         UNIT_BASE     = 4;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SAMPLE  = 2'b01,
        ST_CONVERT = 2'b11
    } sadc_state_t;

endpackage

// ===== sadc_unit_timer.sv
`timescale 1ns/1ps
`default_nettype none

module sadc_unit_timer #(
    parameter int BASE = 4
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // Control
    input  wire logic       clear,
    input  wire logic       enable,
    input  wire logic [2:0] fr_sel,
    // Unit enable pulse
    output logic            tick
);

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] last;

    always_comb begin
        last  = 8'((32'(fr_sel) + 32'd1) * 32'(BASE) - 32'd1);
        tick  = enable && !clear && (cnt_q == last);
        cnt_d = cnt_q;
        if (clear || !enable) begin
            cnt_d = 8'h00;
        end else if (tick) begin
            cnt_d = 8'h00;
        end else begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule // sadc_unit_timer

`default_nettype wire

// ===== sar_adc_select_mode_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module sar_adc_select_mode_control_tb_top;

    // ------------------------------------------------------------
    // Settings and signals
    // ------------------------------------------------------------
    // Unit base 1 with conversion-time select 7 keeps runs short
    localparam int UNIT = 8;
    localparam int CONV = 12 * UNIT;

    logic       core_clk  = 1'b0;
    logic       nrst      = 1'b0;
    logic [2:0] reg_addr  = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic [7:0] reg_rdata;
    logic       comp_in   = 1'b0;
    logic       stop_mode = 1'b0;
    logic [1:0] channel_sel;
    logic       sample_en;
    logic [9:0] dac_code;
    logic       comparator_power_enable;
    logic       conversion_done_irq;
    logic [9:0] target    = 10'h2a5;
    int         failures     = 0;
    int         total_checks = 0;

    always #50 core_clk = ~core_clk;

    // comparator input driven by the bench model every cycle
    // register port written and read during conversions
    // Behavioural input: comparator high while input >= tap
    always @(posedge core_clk) comp_in <= (dac_code <= target);

    sadc_ctrl #(.UNIT_BASE(1)) i_dut (
        .core_clk                (core_clk),
        .nrst                    (nrst),
        .reg_addr                (reg_addr),
        .reg_wdata               (reg_wdata),
        .reg_wr                  (reg_wr),
        .reg_rd                  (reg_rd),
        .reg_rdata               (reg_rdata),
        .comp_in                 (comp_in),
        .stop_mode               (stop_mode),
        .channel_sel             (channel_sel),
        .sample_en               (sample_en),
        .dac_code                (dac_code),
        .comparator_power_enable (comparator_power_enable),
        .conversion_done_irq     (conversion_done_irq)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Bounded wait; sample cycles counted inside the interval only
    task automatic wait_irq(input int lim, output int n, output int smp);
        n   = 0;
        smp = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
            if (sample_en === 1'b1 && n <= CONV) smp++;
        end while (conversion_done_irq !== 1'b1 && n < lim);
        if (conversion_done_irq !== 1'b1) begin
            failures++;
            $display("CHECK FAILED irq wait expected 1 seen 0");
            end_sim();
        end
    endtask

    task automatic quiet(input int cyc, output int hits);
        hits = 0;
        repeat (cyc) begin
            @(posedge core_clk);
            #1;
            if (conversion_done_irq !== 1'b0 || sample_en !== 1'b0) hits++;
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] d;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [9:0] prev;
        int         n;
        int         s;
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;

        // Reset state, unmapped offsets included
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), d);
            chk("reset read", {8'h00, d}, 16'h0000);
        end
        chk("reset irq", {15'h0, conversion_done_irq}, 16'h0000);
        $display("test reset done");

        // Every channel code reaches the selector
        for (int c = 0; c < 4; c++) begin
            wr(sadc_pkg::OFS_CHAN, 8'(c));
            #1 chk("channel_sel", {14'h0, channel_sel}, 16'(c));
            rd(sadc_pkg::OFS_CHAN, d);
            chk("chan read", {8'h00, d}, 16'(c));
        end
        $display("test channel done");

        // Setup, then start after twelve idle cycles
        // channel set before enable here
        wr(sadc_pkg::OFS_MODE, 8'h7f);
        rd(sadc_pkg::OFS_MODE, d);
        chk("mode read", {8'h00, d}, 16'h0039);
        chk("comp power", {15'h0, comparator_power_enable}, 16'h0001);
        repeat (10) @(posedge core_clk);
        // Kept by stimulus: wait before run
        repeat (2) @(posedge core_clk);
        // enable set in every mode write but the last, first result kept
        wr(sadc_pkg::OFS_MODE, 8'hb9);
        wait_irq(CONV + 10, n, s);
        chk("first interval", 16'(n), 16'(CONV));
        chk("sample length", 16'(s), 16'(2 * UNIT));
        wait_irq(CONV + 10, n, s);
        chk("repeat interval", 16'(n), 16'(CONV));
        rd(sadc_pkg::OFS_RES_LO, lo);
        rd(sadc_pkg::OFS_RES_HI, hi);
        chk("result word", {hi, lo}, {target, 6'h00});
        rd(sadc_pkg::OFS_RES_BYTE, d);
        chk("result byte", {8'h00, d}, {8'h00, target[9:2]});
        rd(sadc_pkg::OFS_FLAG, d);
        chk("done flag", {8'h00, d}, 16'h0001);
        $display("test conversion done");

        // Channel write mid-conversion restarts and keeps the flag
        repeat (40) @(posedge core_clk);
        wr(sadc_pkg::OFS_CHAN, 8'h02);
        rd(sadc_pkg::OFS_FLAG, d);
        chk("flag kept", {8'h00, d}, 16'h0001);
        wait_irq(CONV + 10, n, s);
        // Counted from the end of the flag read, two cycles late
        chk("restart interval", 16'(n), 16'(CONV - 2));
        chk("channel_sel new", {14'h0, channel_sel}, 16'h0002);
        wr(sadc_pkg::OFS_FLAG, 8'h01);
        rd(sadc_pkg::OFS_FLAG, d);
        chk("flag cleared", {8'h00, d}, 16'h0000);
        $display("test restart done");

        // Run cleared mid-conversion stops at once
        repeat (30) @(posedge core_clk);
        wr(sadc_pkg::OFS_MODE, 8'h39);
        quiet(2 * CONV, n);
        chk("stopped", 16'(n), 16'h0000);
        rd(sadc_pkg::OFS_RES_BYTE, d);
        chk("result held", {8'h00, d}, {8'h00, target[9:2]});
        $display("test stop done");

        // Stop state halts, release resumes with a new input level
        prev   = target;
        target = 10'h15a;
        wr(sadc_pkg::OFS_MODE, 8'hb9);
        repeat (20) @(posedge core_clk);
        stop_mode <= 1'b1;
        quiet(2 * CONV, n);
        chk("stop state", 16'(n), 16'h0000);
        @(posedge core_clk);
        stop_mode <= 1'b0;
        // Read lands on the completion edge of the resumed run
        repeat (CONV - 1) @(posedge core_clk);
        rd(sadc_pkg::OFS_RES_BYTE, d);
        chk("read first", {8'h00, d}, {8'h00, prev[9:2]});
        chk("resumed irq", {15'h0, conversion_done_irq}, 16'h0001);
        rd(sadc_pkg::OFS_RES_LO, lo);
        rd(sadc_pkg::OFS_RES_HI, hi);
        chk("resumed word", {hi, lo}, {target, 6'h00});
        rd(sadc_pkg::OFS_RES_BYTE, d);
        chk("resumed byte", {8'h00, d}, {8'h00, target[9:2]});
        $display("test stop state done");

        // Channel write on the completion edge cancels the update
        wait_irq(CONV + 10, n, s);
        prev   = target;
        target = 10'h0f3;
        wr(sadc_pkg::OFS_FLAG, 8'h01);
        repeat (CONV - 4) @(posedge core_clk);
        wr(sadc_pkg::OFS_CHAN, 8'h02);
        #1 chk("write wins irq", {15'h0, conversion_done_irq}, 16'h0000);
        rd(sadc_pkg::OFS_FLAG, d);
        chk("write wins flag", {8'h00, d}, 16'h0000);
        rd(sadc_pkg::OFS_RES_BYTE, d);
        chk("write wins byte", {8'h00, d}, {8'h00, prev[9:2]});
        wr(sadc_pkg::OFS_MODE, 8'h00);
        $display("test write wins done");
        end_sim();
    end

endmodule // sar_adc_select_mode_control_tb_top

`default_nettype wire
